// >>> relay_low_side_driver_ctrl.sv
// Top of the six-channel relay driver control block with its Avalon-MM register slave.
//
// What this block does
// RULE_01 - Six independent low-side channels, each with diagnosis and over-current protection.
// RULE_02 - Channel on/off comes only from host-written command bits.
// RULE_03 - Internal chip reset or global disable forces all channels off; chip reset leaves channels a and b on while their hold runs.
// RULE_04 - Channels a and b may stay on through a crank reset when enabled.
// RULE_05 - Hold timer starts on the falling edge of the reset pin.
// RULE_06 - Without host takeover, held channels switch off when the timer expires.
// RULE_07 - Host must leave reset and rewrite the commands within the window.
// RULE_08 - Each of channels a and b has its own hold enable bit.
// RULE_09 - Hold duration lies between 400 ms and 800 ms.
// RULE_10 - Over-current counts as fault only after persisting about 4 us.
// RULE_11 - A confirmed over-current switches the channel off in fast mode.
// RULE_12 - Off-state open-load and ground-short need about 50 us persistence.
// RULE_13 - Off-state diagnosis is masked 300 to 500 us after switch-off.
// RULE_14 - Fault codes: 11 none, 01 open, 10 over-current, 00 ground short.
// RULE_15 - Faults latch until a diagnosis read; first off-state fault is kept.
// RULE_16 - After over-current, re-arm on command low-then-high or each diagnosis read.
// RULE_17 - Off-state: below low ground short, between open, above high none.
// RULE_18 - All filter, mask and hold times come from clock counters.
// RULE_19 - Drive is command gated by reset, disable, over-current latch, hold expiry.
`timescale 1ns/1ps
`include "relay_drv_defines.svh"
module relay_low_side_driver_ctrl #(
  parameter int unsigned MASK_CYC = `MASK_DELAY_CYC,
  parameter int unsigned HOLD_CYC = `HOLD_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_chip_internal_reset,
  input wire logic i_reset_pin,
  input wire logic [5:0] i_ovc,
  input wire logic [5:0] i_above_low,
  input wire logic [5:0] i_above_high,
  output logic [5:0] o_relay_driver_output,
  output logic [5:0] o_fast_off,
  output logic o_irq
);
  logic [19:0] sync1;
  logic [19:0] sync2;
  logic rst_pin_q;
  logic chip_rst;
  logic rst_fall;
  relay_drv_pkg::comp_t comp [6];

  logic [5:0] cmd;
  logic global_output_disable;
  logic ch_a_low_batt_hold_enable;
  logic ch_b_low_batt_hold_enable;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] next_irq_status;
  logic [7:0] next_irq_mask;

  logic access;
  logic wr_ctrl;
  logic diag_read;
  logic status_read;
  logic takeover;
  logic [31:0] next_readdata;
  logic wr_config;
  logic wr_mask;

  logic [5:0] req;
  logic [5:0] on;
  logic [5:0] ovc_off;
  logic [5:0] ch_event;
  relay_drv_pkg::fault_code_t code [6];
  logic [1:0] holding;
  logic [1:0] expired;
  logic [1:0] exp_event;
  logic [1:0] hold_start;
  logic [11:0] diag_word;

  // Pins come from outside the clock domain and pass two flops first.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync1 <= 20'h00000;
      sync2 <= 20'h00000;
    end
    else
    begin
      sync1 <= {i_chip_internal_reset, i_reset_pin, i_ovc, i_above_low, i_above_high};
      sync2 <= sync1;
    end
  end

  assign chip_rst = sync2[19];
  assign rst_fall = rst_pin_q & ~sync2[18];

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_pin_q <= 1'h0;
    end
    else
    begin
      rst_pin_q <= sync2[18];
    end
  end

  // Comparator bits are grouped per channel here; each channel classifies its
  // own pair against the low and high thresholds.
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_comp
      assign comp[g] = '{overcurrent_fault: sync2[12 + g], above_low: sync2[6 + g], above_high: sync2[g]};
    end
  endgenerate

  // The slave answers every request after one wait cycle; read data is loaded
  // on the first edge so it already stands when waitrequest is sampled low.
  // All arguments are passed in so the strobes re-evaluate on every operand.
  function automatic logic reg_hit(input logic strobe, input logic [4:0] addr,
                                   input logic [4:0] reg_addr);
    return strobe & (addr == reg_addr);
  endfunction : reg_hit

  assign access = (i_read | i_write) & ~o_waitrequest;
  assign wr_ctrl = reg_hit(access & i_write, i_address, `ADDR_CTRL);
  assign wr_config = reg_hit(access & i_write, i_address, `ADDR_CONFIG7) & i_byteenable[0];
  assign wr_mask = reg_hit(access & i_write, i_address, `ADDR_IRQ_MASK) & i_byteenable[0];
  assign takeover = wr_ctrl & i_byteenable[0];
  assign diag_read = reg_hit(access & i_read, i_address, `ADDR_DIAG);
  assign status_read = reg_hit(access & i_read, i_address, `ADDR_IRQ_STATUS);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_waitrequest <= 1'h1;
    end
    else
    begin
      o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cmd <= `CMD_RESET;
      global_output_disable <= `DISABLE_RESET;
    end
    else if (wr_ctrl)
    begin
      if (i_byteenable[0])
      begin
        cmd <= i_writedata[`CTRL_CMD_LSB +: 6]; // see RULE_02
      end
      if (i_byteenable[1])
      begin
        global_output_disable <= i_writedata[`CTRL_DISABLE_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ch_a_low_batt_hold_enable <= 1'(`CFG7_RESET >> `CFG7_HOLD_A_BIT);
      ch_b_low_batt_hold_enable <= 1'(`CFG7_RESET >> `CFG7_HOLD_B_BIT);
    end
    else if (wr_config)
    begin
      ch_a_low_batt_hold_enable <= i_writedata[`CFG7_HOLD_A_BIT]; // see RULE_08
      ch_b_low_batt_hold_enable <= i_writedata[`CFG7_HOLD_B_BIT]; // see RULE_08
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      irq_mask <= `IRQ_MASK_RESET;
    end
    else if (wr_mask)
    begin
      irq_mask <= i_writedata[7:0];
    end
  end

  // The level output follows a mask write at the same edge as the mask itself.
  always_comb
  begin
    next_irq_mask = irq_mask;
    if (wr_mask)
    begin
      next_irq_mask = i_writedata[7:0];
    end
  end

  // A new event in the cycle of a status read stays set.
  always_comb
  begin
    next_irq_status = status_read ? 8'h00 : irq_status;
    next_irq_status = next_irq_status | {exp_event, ch_event};
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      irq_status <= 8'h00;
      o_irq <= 1'h0;
    end
    else
    begin
      irq_status <= next_irq_status;
      o_irq <= |(next_irq_status & next_irq_mask);
    end
  end

  generate
    for (g = 0; g < 6; g++)
    begin : g_diag
      assign diag_word[2 * g +: 2] = code[g];
    end
  endgenerate

  always_comb
  begin
    case (i_address)
      `ADDR_CTRL: next_readdata = {23'h000000, global_output_disable, 2'h0, cmd};
      `ADDR_CONFIG7: next_readdata = {30'h00000000, ch_b_low_batt_hold_enable,
        ch_a_low_batt_hold_enable};
      `ADDR_DIAG: next_readdata = {20'h00000, diag_word};
      `ADDR_IRQ_STATUS: next_readdata = {24'h000000, irq_status};
      `ADDR_IRQ_MASK: next_readdata = {24'h000000, irq_mask};
      `ADDR_STATE: next_readdata = {12'h000, expired, holding, 2'h0, ovc_off, 2'h0, on};
      default: next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_readdata <= 32'h00000000;
    end
    else if (i_read && o_waitrequest)
    begin
      o_readdata <= next_readdata;
    end
  end

  low_batt_hold #(
    .HOLD_CYC(HOLD_CYC)
  ) u_hold_a (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(rst_fall),
    .i_enable(ch_a_low_batt_hold_enable & cmd[0]),
    .i_takeover(takeover),
    .o_holding(holding[0]),
    .o_expired(expired[0]),
    .o_exp_event(exp_event[0])
  ); // see RULE_09

  low_batt_hold #(
    .HOLD_CYC(HOLD_CYC)
  ) u_hold_b (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(rst_fall),
    .i_enable(ch_b_low_batt_hold_enable & cmd[1]),
    .i_takeover(takeover),
    .o_holding(holding[1]),
    .o_expired(expired[1]),
    .o_exp_event(exp_event[1])
  ); // see RULE_18

  // The timer only shows running one edge after the reset fall is seen, so the
  // start itself bridges that cycle; otherwise a held channel would drop once.
  assign hold_start = {2{rst_fall}} & {ch_b_low_batt_hold_enable, ch_a_low_batt_hold_enable};

  // Channels a and b ride through the chip reset only while their hold runs.
  always_comb
  begin
    req = cmd & {6{~global_output_disable & ~chip_rst}}; // see RULE_03
    req[1:0] = cmd[1:0] & ~expired & {2{~global_output_disable}}
      & ({2{~chip_rst}} | holding | hold_start); // see RULE_04
  end

  generate
    for (g = 0; g < 6; g++)
    begin : g_ch
      relay_channel #(
        .MASK_CYC(MASK_CYC)
      ) u_ch (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_req(req[g]),
        .i_cmd(cmd[g]),
        .i_comp(comp[g]),
        .i_diag_read(diag_read),
        .o_on(on[g]),
        .o_ovc_off(ovc_off[g]),
        .o_code(code[g]),
        .o_event(ch_event[g])
      ); // see RULE_01
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_relay_driver_output <= 6'h00;
      o_fast_off <= 6'h00;
    end
    else
    begin
      o_relay_driver_output <= on; // see RULE_19
      o_fast_off <= ovc_off; // see RULE_11
    end
  end

endmodule : relay_low_side_driver_ctrl

// >>> relay_drv_defines.svh
// Offsets, field positions, reset values and timing counts of the relay driver block.
`ifndef RELAY_DRV_DEFINES_SVH
`define RELAY_DRV_DEFINES_SVH

`define CLK_HZ 20000000
`define CYC_PER_US (`CLK_HZ / 1000000)

`define OVC_FILT_NS 4000
`define OVC_FILT_CYC ((`OVC_FILT_NS * `CYC_PER_US + 999) / 1000)
`define DIAG_FILT_NS 50000
`define DIAG_FILT_CYC ((`DIAG_FILT_NS * `CYC_PER_US + 999) / 1000)
`define MASK_DELAY_US 400
`define MASK_DELAY_CYC (`MASK_DELAY_US * `CYC_PER_US)
`define HOLD_MS 600
`define HOLD_CYC (`HOLD_MS * 1000 * `CYC_PER_US)

`define ADDR_CTRL 5'h00
`define ADDR_CONFIG7 5'h04
`define ADDR_DIAG 5'h08
`define ADDR_IRQ_STATUS 5'h0c
`define ADDR_IRQ_MASK 5'h10
`define ADDR_STATE 5'h14

`define CTRL_CMD_LSB 0
`define CTRL_DISABLE_BIT 8
`define CFG7_HOLD_A_BIT 0
`define CFG7_HOLD_B_BIT 1
`define IRQ_EXP_A_BIT 6
`define IRQ_EXP_B_BIT 7

`define CMD_RESET 6'h00
`define DISABLE_RESET 1'h0
`define CFG7_RESET 2'h0
`define IRQ_MASK_RESET 8'h00

`endif

// >>> relay_drv_pkg.sv
// Types shared by the relay driver block.
package relay_drv_pkg;
  typedef struct packed {
    logic overcurrent_fault;
    logic above_low;
    logic above_high;
  } comp_t;

  typedef enum logic [1:0] {
    FAULT_SCG = 2'h0,
    FAULT_OPEN = 2'h1,
    FAULT_OVC = 2'h2,
    FAULT_NONE = 2'h3
  } fault_code_t;

  typedef enum {CH_ON, CH_MASK, CH_DIAG} ch_state_t;
  typedef enum {HOLD_IDLE, HOLD_RUN, HOLD_EXPIRED} hold_state_t;
endpackage : relay_drv_pkg

// >>> relay_channel.sv
// One protected relay driver channel: over-current filter, off-state diagnosis, fault latch.
`timescale 1ns/1ps
`include "relay_drv_defines.svh"
module relay_channel #(
  parameter int unsigned MASK_CYC = `MASK_DELAY_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_req,
  input wire logic i_cmd,
  input relay_drv_pkg::comp_t i_comp,
  input wire logic i_diag_read,
  output logic o_on,
  output logic o_ovc_off,
  output relay_drv_pkg::fault_code_t o_code,
  output logic o_event
);
  relay_drv_pkg::ch_state_t state;
  relay_drv_pkg::fault_code_t cls;
  relay_drv_pkg::fault_code_t last_cls;
  logic [6:0] ovc_cnt;
  logic [15:0] cnt;
  logic confirm;
  logic off_fault;

  function automatic relay_drv_pkg::fault_code_t classify(input relay_drv_pkg::comp_t c);
    if (!c.above_low)
    begin
      return relay_drv_pkg::FAULT_SCG;
    end
    if (!c.above_high)
    begin
      return relay_drv_pkg::FAULT_OPEN;
    end
    return relay_drv_pkg::FAULT_NONE;
  endfunction : classify

  assign o_on = i_req & ~o_ovc_off;
  assign cls = classify(i_comp); // see RULE_17
  assign confirm = o_on & i_comp.overcurrent_fault & (ovc_cnt == 7'(`OVC_FILT_CYC - 1)); // see RULE_10
  assign off_fault = (state == relay_drv_pkg::CH_DIAG) & (cls == last_cls)
    & (cnt == 16'(`DIAG_FILT_CYC - 1)) & (cls != relay_drv_pkg::FAULT_NONE); // see RULE_12
  assign o_event = confirm | (off_fault & (o_code == relay_drv_pkg::FAULT_NONE));

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ovc_cnt <= 7'h00;
    end
    else if (o_on && i_comp.overcurrent_fault && !confirm)
    begin
      ovc_cnt <= ovc_cnt + 7'h01;
    end
    else
    begin
      ovc_cnt <= 7'h00;
    end
  end

  // A confirmed fault wins over a re-arm arriving in the same cycle.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ovc_off <= 1'h0;
    end
    else if (confirm)
    begin
      o_ovc_off <= 1'h1; // see RULE_11
    end
    else if (!i_cmd || i_diag_read)
    begin
      o_ovc_off <= 1'h0; // see RULE_16
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= relay_drv_pkg::CH_MASK;
      cnt <= 16'h0000;
      last_cls <= relay_drv_pkg::FAULT_NONE;
    end
    else if (o_on)
    begin
      state <= relay_drv_pkg::CH_ON;
      cnt <= 16'h0000;
    end
    else
    begin
      case (state)
        relay_drv_pkg::CH_ON:
        begin
          state <= relay_drv_pkg::CH_MASK;
          cnt <= 16'h0000;
        end
        relay_drv_pkg::CH_MASK:
        begin
          if (cnt == 16'(MASK_CYC - 1))
          begin
            state <= relay_drv_pkg::CH_DIAG; // see RULE_13
            cnt <= 16'h0000;
            last_cls <= cls;
          end
          else
          begin
            cnt <= cnt + 16'h0001;
          end
        end
        relay_drv_pkg::CH_DIAG:
        begin
          last_cls <= cls;
          if (cls != last_cls || off_fault)
          begin
            cnt <= 16'h0000;
          end
          else
          begin
            cnt <= cnt + 16'h0001;
          end
        end
        default:
        begin
          state <= relay_drv_pkg::CH_MASK;
          cnt <= 16'h0000;
        end
      endcase
    end
  end

  // An on-state fault always overwrites; an off-state fault only lands on a clean code.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_code <= relay_drv_pkg::FAULT_NONE;
    end
    else if (confirm)
    begin
      o_code <= relay_drv_pkg::FAULT_OVC; // see RULE_14
    end
    else if (off_fault && o_code == relay_drv_pkg::FAULT_NONE)
    begin
      o_code <= cls; // see RULE_15
    end
    else if (i_diag_read)
    begin
      o_code <= relay_drv_pkg::FAULT_NONE; // see RULE_15
    end
  end
endmodule : relay_channel

// >>> low_batt_hold.sv
// Low-battery hold timer for one channel that may outlast a crank reset.
`timescale 1ns/1ps
`include "relay_drv_defines.svh"
module low_batt_hold #(
  parameter int unsigned HOLD_CYC = `HOLD_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_enable,
  input wire logic i_takeover,
  output logic o_holding,
  output logic o_expired,
  output logic o_exp_event
);
  relay_drv_pkg::hold_state_t state;
  logic [23:0] cnt;

  assign o_holding = (state == relay_drv_pkg::HOLD_RUN);
  assign o_expired = (state == relay_drv_pkg::HOLD_EXPIRED);
  assign o_exp_event = o_holding & (cnt == 24'(HOLD_CYC - 1)) & ~i_takeover;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= relay_drv_pkg::HOLD_IDLE;
      cnt <= 24'h000000;
    end
    else if (i_start && i_enable)
    begin
      state <= relay_drv_pkg::HOLD_RUN; // see RULE_05
      cnt <= 24'h000000;
    end
    else
    begin
      case (state)
        relay_drv_pkg::HOLD_RUN:
        begin
          if (i_takeover)
          begin
            state <= relay_drv_pkg::HOLD_IDLE; // see RULE_07
          end
          else if (o_exp_event)
          begin
            state <= relay_drv_pkg::HOLD_EXPIRED; // see RULE_06
          end
          else
          begin
            cnt <= cnt + 24'h000001;
          end
        end
        relay_drv_pkg::HOLD_EXPIRED:
        begin
          if (i_takeover)
          begin
            state <= relay_drv_pkg::HOLD_IDLE;
          end
        end
        default:
        begin
          state <= relay_drv_pkg::HOLD_IDLE;
        end
      endcase
    end
  end
endmodule : low_batt_hold

// >>> relay_drv_monitor.sv
// Concurrent checks on the ports of the relay driver control block.
`timescale 1ns/1ps
module relay_drv_monitor #(
  parameter int unsigned HOLD_CYC = 12000000
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic i_chip_internal_reset,
  input wire logic i_reset_pin,
  input wire logic [5:0] i_ovc,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic [5:0] o_relay_driver_output,
  input wire logic [5:0] o_fast_off
);
  int ovc_run [6];
  int on_ovc_run [6];
  int crst_run;

  // Chip reset held without a new crank edge: any hold must have run out by then.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      crst_run <= 0;
    end
    else if (!i_chip_internal_reset || $fell(i_reset_pin))
    begin
      crst_run <= 0;
    end
    else
    begin
      crst_run <= crst_run + 1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    for (int g = 0; g < 6; g++)
    begin
      if (!i_resetn)
      begin
        ovc_run[g] <= 0;
        on_ovc_run[g] <= 0;
      end
      else
      begin
        ovc_run[g] <= i_ovc[g] ? ovc_run[g] + 1 : 0;
        on_ovc_run[g] <= (i_ovc[g] && o_relay_driver_output[g]) ? on_ovc_run[g] + 1 : 0;
      end
    end
  end

  chk_wait_answers: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered on the next edge");
  chk_wait_single: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_rdata_holds: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_waitrequest |-> $stable(o_readdata))
    else $error("read data changed outside a read");
  chk_crst_forces_off: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_chip_internal_reset [*5] |-> o_relay_driver_output[5:2] == 4'h0)
    else $error("channel driven during chip reset");
  chk_hold_expires: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    crst_run > HOLD_CYC + 8 |-> o_relay_driver_output == 6'h00)
    else $error("held channel still on after hold time");

  for (genvar g = 0; g < 6; g++)
  begin : per_ch
    chk_ovc_filter_min: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      $rose(o_fast_off[g]) |-> ovc_run[g] >= 80)
      else $error("fast off before over-current filter time");
    chk_ovc_switch_off: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      on_ovc_run[g] < 90)
      else $error("over-current channel not switched off");
    chk_fast_off_gates: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      o_fast_off[g] |-> !o_relay_driver_output[g])
      else $error("channel on while latched off by over-current");
  end
endmodule : relay_drv_monitor

bind relay_low_side_driver_ctrl relay_drv_monitor #(.HOLD_CYC(HOLD_CYC)) u_mon (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_read(i_read), .i_write(i_write),
  .i_chip_internal_reset(i_chip_internal_reset), .i_reset_pin(i_reset_pin), .i_ovc(i_ovc),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_relay_driver_output(o_relay_driver_output), .o_fast_off(o_fast_off)
);

// >>> relay_load_model.sv
// Behavioural loads on the six relay outputs, giving comparator levels per fault kind.
`timescale 1ns/1ps
module relay_load_model (
  input wire logic [5:0] i_drive,
  input wire logic [11:0] i_mode,
  output logic [5:0] o_ovc,
  output logic [5:0] o_above_low,
  output logic [5:0] o_above_high
);
  // Mode per channel uses the fault code layout; a driven output sits near ground.
  always_comb
  begin
    for (int g = 0; g < 6; g++)
    begin
      o_ovc[g] = i_drive[g] && (i_mode[2*g+:2] == 2'h2);
      o_above_low[g] = !i_drive[g] && (i_mode[2*g+:2] != 2'h0);
      o_above_high[g] = !i_drive[g] && i_mode[2*g+1];
    end
  end
endmodule : relay_load_model

// >>> relay_low_side_driver_ctrl_tb.sv
// Self-checking bench for the relay driver control block.
`timescale 1ns/1ps
module relay_low_side_driver_ctrl_tb;
  localparam int unsigned HOLD = 200;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [4:0] i_address = 5'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic i_chip_internal_reset = 1'b0;
  logic i_reset_pin = 1'b1;
  logic [11:0] mode = 12'hfff;
  logic [5:0] overcurrent_fault, alow, ahigh, out, foff;
  logic [31:0] rdata, lfsr = 32'h598ee227;
  logic irq;
  logic wait_req;
  logic [3:0] be = 4'hf;
  int bad_count = 0;
  int num_checks = 0;

  relay_low_side_driver_ctrl #(.MASK_CYC(20), .HOLD_CYC(HOLD)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(be),
    .o_readdata(rdata), .o_waitrequest(wait_req), .i_chip_internal_reset(i_chip_internal_reset),
    .i_reset_pin(i_reset_pin), .i_ovc(overcurrent_fault), .i_above_low(alow), .i_above_high(ahigh),
    .o_relay_driver_output(out), .o_fast_off(foff), .o_irq(irq));
  relay_load_model u_load (.i_drive(out), .i_mode(mode), .o_ovc(overcurrent_fault),
    .o_above_low(alow), .o_above_high(ahigh));

  initial
  begin
    forever #25 i_clk = ~i_clk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  function automatic logic [31:0] exp_out(input logic [8:0] c, input logic crst);
    return (c[8] || crst) ? 32'h0 : {26'h0, c[5:0]};
  endfunction : exp_out

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Pre-edge values are read at the edge, so the answer is the settled one.
  // Only the watchdog ends a wait that never sees waitrequest low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    do
    begin
      @(posedge i_clk);
    end
    while (wait_req !== 1'b0);
    q = rdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wait_cyc

  task automatic crank(input logic crst);
    i_chip_internal_reset <= crst;
    i_reset_pin <= !crst;
    wait_cyc(30);
  endtask : crank

  initial
  begin
    wait_cyc(20000);
    bad_count++;
    results();
  end

  initial
  begin
    logic [8:0] c;
    wait_cyc(16);
    i_resetn <= 1'b1;
    wait_cyc(1);
    rd_chk("ctrl", 5'h00, 32'h0);
    rd_chk("config7", 5'h04, 32'h0);
    rd_chk("irq mask", 5'h10, 32'h0);
    wr(5'h18, 32'hffffffff);
    rd_chk("unmapped", 5'h18, 32'h0);
    wait_cyc(1100);
    rd_chk("diag idle", 5'h08, 32'hfff);
    for (int i = 0; i < 10; i++)
    begin
      lfsr = next_rand(lfsr);
      c = (i == 0) ? 9'h13f : lfsr[8:0] & 9'h13f;
      wr(5'h00, {23'h0, c});
      wait_cyc(4);
      chk("drive", exp_out(c, 1'b0), {26'h0, out});
    end
    wr(5'h00, 32'h3f);
    i_chip_internal_reset <= 1'b1;
    wait_cyc(6);
    chk("chip reset", exp_out(9'h3f, 1'b1), {26'h0, out});
    i_chip_internal_reset <= 1'b0;
    wait_cyc(6);
    chk("after chip reset", exp_out(9'h3f, 1'b0), {26'h0, out});
    be <= 4'h2;
    wr(5'h00, 32'h100);
    rd_chk("lane one only", 5'h00, 32'h13f);
    chk("disable lane", exp_out(9'h13f, 1'b0), {26'h0, out});
    be <= 4'hf;
    wr(5'h00, 32'h3f);
    wr(5'h10, 32'h4);
    rd_chk("status clean", 5'h0c, 32'h0);
    mode <= 12'hfef;
    wait_cyc(70);
    chk("ovc filtered", 32'h1, {31'h0, out[2]});
    wait_cyc(30);
    chk("ovc off", 32'h3, {29'h0, out[2], foff[2], irq});
    mode <= 12'hfff;
    wait_cyc(4);
    rd_chk("ovc code", 5'h08, 32'hfef);
    wait_cyc(3);
    chk("rearm", 32'h2, {30'h0, out[2], foff[2]});
    rd_chk("irq status", 5'h0c, 32'h4);
    wait_cyc(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    mode <= 12'hc7f;
    wr(5'h00, 32'h07);
    wait_cyc(600);
    rd_chk("mask and filter", 5'h08, 32'hfff);
    wait_cyc(600);
    mode <= 12'hc3f;
    wait_cyc(1100);
    chk("masked irq", 32'h0, {31'h0, irq});
    rd_chk("offstate codes", 5'h08, 32'hc7f);
    mode <= 12'hfff;
    wr(5'h04, 32'h3);
    wr(5'h00, 32'h3f);
    rd_chk("status", 5'h0c, 32'h18);
    crank(1'b1);
    chk("holding", 32'h3, {26'h0, out});
    wait_cyc(HOLD);
    chk("hold expired", 32'h0, {26'h0, out});
    rd_chk("hold events", 5'h0c, 32'hc0);
    crank(1'b0);
    wr(5'h04, 32'h1);
    wr(5'h00, 32'h3f);
    crank(1'b1);
    chk("single hold", 32'h1, {26'h0, out});
    crank(1'b0);
    wr(5'h00, 32'h3f);
    wait_cyc(HOLD + 50);
    chk("takeover", 32'h3f, {26'h0, out});
    results();
  end
endmodule : relay_low_side_driver_ctrl_tb
